// ---- common/ccu_pkg.sv ----
// Constants and types for the compare unit of the capture/compare/PWM block.
// Assumes an APB master with 32-bit data and byte addressing.
package ccu_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_VALUE_LOW = 8'h04;
  localparam logic [7:0] OFS_VALUE_HIGH = 8'h08;
  localparam logic [7:0] OFS_ENABLES = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BIT_EVENT = 5;
  localparam int BIT_OVERFLOW = 0;
  localparam logic [7:0] FLAG_MASK = 8'h21;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] DUTY_LO_BITS = 2'h0;

  // ----------------------------------------------------------------------
  // Mode select encodings
  // ----------------------------------------------------------------------
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_SOFT_IRQ = 4'ha;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic [1:0] output_steering_select;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_select;
  } ccu_ctrl_s;

  // Timer1 side of the unit.
  typedef struct packed {
    logic [15:0] count;
    logic tick;
    logic overflow;
  } ccu_timer_s;

endpackage : ccu_pkg

// ---- hw/ccu_compare_unit.sv ----
// Compare unit with special event trigger, single-pin PWM and APB registers.
// Assumes Timer1 and Timer2 live outside and run on pclk; Timer1 updates
// only in cycles with tick high, and clears instead of counting when
// timer_clear is high in its tick cycle.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RL1 - Compare the 16-bit pair with the Timer1 count on each update.
// RL2 - A match does one action: toggle, set, clear, trigger or flag only.
// RL3 - Every compare mode sets the event flag on a match.
// RL4 - Writing zero to control forces the compare latch low.
// RL5 - Mode 1010 sets the flag only and leaves the pin alone.
// RL6 - Mode 1011 resets Timer1 and starts ADC when the ADC is enabled.
// RL7 - Special event mode does not take the pin.
// RL8 - Special event trigger asserts in the same cycle equality is seen.
// RL9 - Timer1 clears at its next clock edge, making the pair a period.
// RL10 - Special event reset never sets the Timer1 overflow flag.
// RL11 - If the match goes away before the Timer1 edge, no reset.
// RL12 - Software runs Timer1 in timer or synchronized counter mode.
// RL13 - Software clears the pin direction bit for compare output.
// RL14 - Software clears control before writing a new prescaler mode.
// RL15 - PWM mode drives a 10-bit duty pulse on the pin.
// RL16 - Writing zero to control releases the pin to the port.
// RL17 - Codes 0010 toggle, 1000 set, 1001 clear, each flagging on match.
// RL18 - Mode 0000 turns the unit off and resets its state.
// RL19 - Hardware never clears the event flag; software does.
// RL20 - Flag and pin action happen once on entry into equality.
module ccu_compare_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer1
  input wire ccu_pkg::ccu_timer_s timer_one,
  output logic timer_clear,
  // Timer2 time base for PWM
  input wire logic [9:0] pwm_time_base,
  input wire logic pwm_period_start,
  // ADC
  input wire logic adc_enabled,
  output logic adc_start,
  output logic special_event_trigger,
  // Pin and interrupt levels
  output logic unit_pin_out,
  output logic unit_pin_drive_n,
  output logic unit_event_flag,
  output logic unit_event_enable
);

  // ----------------------------------------------------------------------
  // Mode helpers
  // ----------------------------------------------------------------------

  // True for the five compare sub-modes.
  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m == ccu_pkg::MODE_TOGGLE) || (m == ccu_pkg::MODE_SET) ||
                 (m == ccu_pkg::MODE_CLEAR) ||
                 (m == ccu_pkg::MODE_SOFT_IRQ) ||
                 (m == ccu_pkg::MODE_SPECIAL);
  endfunction

  // True for the modes in which the unit owns the pin.
  function automatic logic owns_pin(input logic [3:0] m);
    owns_pin = (m == ccu_pkg::MODE_TOGGLE) || (m == ccu_pkg::MODE_SET) ||
               (m == ccu_pkg::MODE_CLEAR) ||
               (m[3:2] == ccu_pkg::MODE_PWM_TOP);
  endfunction

  // ----------------------------------------------------------------------
  // Registers and wires
  // ----------------------------------------------------------------------
  ccu_pkg::ccu_ctrl_s ctrl_r;
  logic [7:0] value_low_r;
  logic [7:0] value_high_r;
  logic enable_evt_r;
  logic enable_ovf_r;
  logic flag_evt_r;
  logic flag_ovf_r;
  logic match_prev_r;
  logic pin_r;
  logic [9:0] duty_latch_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [3:0] mode;
  logic match;
  logic match_entry;
  logic sev_mode;
  logic wr_en;
  logic rd_take;
  logic addr_ok;
  logic [7:0] rd_byte;

  assign mode = ctrl_r.unit_mode_select;
  assign sev_mode = (mode == ccu_pkg::MODE_SPECIAL);

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------

  // One wait state so that read data comes straight from a flip-flop.
  assign rd_take = psel && penable && !pready_r;
  assign wr_en = psel && penable && pready_r && pwrite && addr_ok;
  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r && pready_r;

  // Address decode for the five registers.
  always_comb begin
    addr_ok = 1'b1;
    rd_byte = ccu_pkg::RST_BYTE;
    if (paddr == ccu_pkg::OFS_CONTROL) begin
      rd_byte = ctrl_r;
    end else if (paddr == ccu_pkg::OFS_VALUE_LOW) begin
      rd_byte = value_low_r;
    end else if (paddr == ccu_pkg::OFS_VALUE_HIGH) begin
      rd_byte = value_high_r;
    end else if (paddr == ccu_pkg::OFS_ENABLES) begin
      rd_byte[ccu_pkg::BIT_EVENT] = enable_evt_r;
      rd_byte[ccu_pkg::BIT_OVERFLOW] = enable_ovf_r;
    end else if (paddr == ccu_pkg::OFS_FLAGS) begin
      rd_byte[ccu_pkg::BIT_EVENT] = flag_evt_r;
      rd_byte[ccu_pkg::BIT_OVERFLOW] = flag_ovf_r;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Handshake and read data capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= rd_take;
      if (rd_take) begin
        prdata_r <= {24'h00_0000, rd_byte};
        pslverr_r <= !addr_ok;
      end
    end
  end

  // Plain read/write registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= ccu_pkg::RST_BYTE;
      value_low_r <= ccu_pkg::RST_BYTE;
      value_high_r <= ccu_pkg::RST_BYTE;
      enable_evt_r <= 1'b0;
      enable_ovf_r <= 1'b0;
    end else if (wr_en) begin
      if (paddr == ccu_pkg::OFS_CONTROL) begin
        ctrl_r <= pwdata[7:0];
      end else if (paddr == ccu_pkg::OFS_VALUE_LOW) begin
        value_low_r <= pwdata[7:0];
      end else if (paddr == ccu_pkg::OFS_VALUE_HIGH) begin
        value_high_r <= pwdata[7:0];
      end else if (paddr == ccu_pkg::OFS_ENABLES) begin
        enable_evt_r <= pwdata[ccu_pkg::BIT_EVENT];
        enable_ovf_r <= pwdata[ccu_pkg::BIT_OVERFLOW];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Compare and special event
  // ----------------------------------------------------------------------

  // Equality is live, so a pair rewrite removes a pending reset at once.
  assign match = is_compare(mode) &&
                 (timer_one.count == {value_high_r, value_low_r}); // RL1
  assign match_entry = match && !match_prev_r; // RL20
  assign special_event_trigger = sev_mode && match; // RL8
  assign timer_clear = special_event_trigger && timer_one.tick; // RL9 RL11
  assign adc_start = sev_mode && match_entry && adc_enabled; // RL6

  // Remembers equality so the action fires once per entry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_prev_r <= 1'b0;
    end else if (mode == ccu_pkg::MODE_OFF) begin
      match_prev_r <= 1'b0; // RL18
    end else begin
      match_prev_r <= match;
    end
  end

  // ----------------------------------------------------------------------
  // Flags: hardware sets win over a software clear in the same cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_evt_r <= 1'b0;
      flag_ovf_r <= 1'b0;
    end else begin
      if (match_entry) begin
        flag_evt_r <= 1'b1; // RL3 RL5 RL17
      end else if (wr_en && paddr == ccu_pkg::OFS_FLAGS) begin
        flag_evt_r <= pwdata[ccu_pkg::BIT_EVENT]; // RL19
      end
      // A cleared-by-trigger Timer1 never wraps, so no overflow is seen.
      if (timer_one.overflow && !timer_clear) begin
        flag_ovf_r <= 1'b1; // RL10
      end else if (wr_en && paddr == ccu_pkg::OFS_FLAGS) begin
        flag_ovf_r <= pwdata[ccu_pkg::BIT_OVERFLOW];
      end
    end
  end

  assign unit_event_flag = flag_evt_r;
  assign unit_event_enable = enable_evt_r;

  // ----------------------------------------------------------------------
  // Pin latch, shared by compare and PWM
  // ----------------------------------------------------------------------

  // The latch is separate from the port data latch and idles low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r <= 1'b0;
      duty_latch_r <= 10'h000;
    end else if (mode == ccu_pkg::MODE_OFF) begin
      pin_r <= 1'b0; // RL4 RL18
      duty_latch_r <= 10'h000;
    end else if (mode[3:2] == ccu_pkg::MODE_PWM_TOP) begin
      // Duty is latched only at a period start, so edits never glitch.
      if (pwm_period_start) begin
        duty_latch_r <= {value_low_r, ctrl_r.duty_low_bits};
        pin_r <= ({value_low_r, ctrl_r.duty_low_bits} != 10'h000); // RL15
      end else if (pwm_time_base == duty_latch_r) begin
        pin_r <= 1'b0; // RL15
      end
    end else if (match_entry) begin
      case (mode)
        ccu_pkg::MODE_TOGGLE: begin
          pin_r <= !pin_r; // RL2 RL17
        end
        ccu_pkg::MODE_SET: begin
          pin_r <= 1'b1; // RL2 RL17
        end
        ccu_pkg::MODE_CLEAR: begin
          pin_r <= 1'b0; // RL2 RL17
        end
        default: begin
          pin_r <= pin_r; // RL5 RL7
        end
      endcase
    end
  end

  assign unit_pin_out = pin_r;
  assign unit_pin_drive_n = !owns_pin(mode); // RL7 RL16

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_entry;
    match_entry && (mode == ccu_pkg::MODE_SET);
  endsequence

  sequence s_high_holds;
    (pin_r && mode == ccu_pkg::MODE_SET)[*2];
  endsequence

  property p_set_pin;
    s_entry |=> s_high_holds or (mode != ccu_pkg::MODE_SET);
  endproperty
  a_set_pin: assert property (p_set_pin) // RL17
    else $error("Set mode did not drive the pin high.");

  property p_flag_on_entry;
    match_entry |=> flag_evt_r;
  endproperty
  a_flag_on_entry: assert property (p_flag_on_entry) // RL3
    else $error("Event flag not set after a match.");

  property p_once;
    match_entry |=> !match_entry;
  endproperty
  a_once: assert property (p_once) // RL20
    else $error("Match action repeated while equal.");

  property p_trigger_now;
    (sev_mode && timer_one.count == {value_high_r, value_low_r})
      |-> special_event_trigger;
  endproperty
  a_trigger_now: assert property (p_trigger_now) // RL8
    else $error("Special event trigger late.");

  property p_no_clear_without_match;
    timer_clear |-> match && sev_mode && timer_one.tick;
  endproperty
  a_no_clear_without_match: assert property (p_no_clear_without_match) // RL11
    else $error("Timer1 cleared without a live match.");

  property p_sev_no_pin;
    (mode == ccu_pkg::MODE_SPECIAL || mode == ccu_pkg::MODE_SOFT_IRQ)
      |-> unit_pin_drive_n;
  endproperty
  a_sev_no_pin: assert property (p_sev_no_pin) // RL7
    else $error("Unit took the pin in a no-pin mode.");

  // The pin is released at once; the latch is low one edge later, so a
  // mode written at that edge does not trip the check.
  property p_off_low;
    (mode == ccu_pkg::MODE_OFF) |-> unit_pin_drive_n ##1 !pin_r;
  endproperty
  a_off_low: assert property (p_off_low) // RL4
    else $error("Pin latch not low or pin held while off.");

  property p_soft_keeps_pin;
    (mode == ccu_pkg::MODE_SOFT_IRQ) ##1 (mode == ccu_pkg::MODE_SOFT_IRQ)
      |-> $stable(pin_r);
  endproperty
  a_soft_keeps_pin: assert property (p_soft_keeps_pin) // RL5
    else $error("Pin latch changed in flag-only mode.");

  property p_no_ovf_on_clear;
    (timer_clear && !flag_ovf_r &&
     !(wr_en && paddr == ccu_pkg::OFS_FLAGS)) |=> !flag_ovf_r;
  endproperty
  a_no_ovf_on_clear: assert property (p_no_ovf_on_clear) // RL10
    else $error("Trigger reset set the overflow flag.");

  // A toggle entry must invert the latch at the next edge.
  property p_toggle_flips;
    (match_entry && mode == ccu_pkg::MODE_TOGGLE) |=> (pin_r != $past(pin_r));
  endproperty
  a_toggle_flips: assert property (p_toggle_flips) // RL17
    else $error("Toggle mode did not invert the pin latch.");

  // A clear entry must leave the latch low at the next edge.
  property p_clear_drives_low;
    (match_entry && mode == ccu_pkg::MODE_CLEAR) |=> !pin_r;
  endproperty
  a_clear_drives_low: assert property (p_clear_drives_low) // RL2
    else $error("Clear mode did not drive the pin low.");

endmodule : ccu_compare_unit

`default_nettype wire

// ---- test/ccu_timer_model.sv ----
// Timer1 partner: a 16-bit up counter with a tick and a wrap pulse.
// Assumes one pclk domain; the bench loads and runs it by NBA.
`timescale 1ns/1ps
`default_nettype none
module ccu_timer_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_val,
  // Unit side
  input wire logic timer_clear,
  output logic [17:0] timer_one
);
  logic [15:0] cnt_r;
  logic ovf_r;
  // Synchronous timer mode: every running pclk is an update.
  assign timer_one = {cnt_r, run, ovf_r};
  // A clear replaces the step and is never reported as a wrap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      ovf_r <= 1'b0;
    end else if (load) begin
      cnt_r <= load_val;
      ovf_r <= 1'b0;
    end else if (run) begin
      cnt_r <= timer_clear ? 16'h0000 : cnt_r + 16'h0001;
      ovf_r <= !timer_clear && (cnt_r == 16'hffff);
    end else begin
      ovf_r <= 1'b0;
    end
  end
endmodule // ccu_timer_model
`default_nettype wire

// ---- test/tb_ccu_compare_unit.sv ----
// Self-checking bench for the compare unit over APB.
// Assumes the unit, the Timer1 model and the PWM time base share pclk.
`timescale 1ns/1ps
`default_nettype none
module tb_ccu_compare_unit;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, tclr, adc_go, sev, pin, pin_n, evf, eve;
  logic [17:0] tmr;
  logic adc_en = 1'b0;
  logic run = 1'b0;
  logic load = 1'b0;
  logic [15:0] load_val = 16'h0000;
  logic [9:0] tbase = 10'h000;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int checked = 0;
  int adc_cnt = 0;
  int sev_bad = 0;
  bit sp_on = 0;
  // Clock, and a 16-step PWM time base that restarts each period.
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    tbase <= (tbase == 10'h00f) ? 10'h000 : tbase + 10'h001;
  end
  // Watch the trigger against the live count; a count past the pair
  // means the period reset was missed.
  always @(negedge pclk) begin
    if (adc_go === 1'b1) adc_cnt++;
    if (sp_on && ((sev !== (tmr[17:2] == 16'h0010)) || tmr[17:2] > 16'h0010))
      sev_bad++;
  end
  ccu_compare_unit ccu_compare_unit_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_one(tmr), .timer_clear(tclr), .pwm_time_base(tbase),
    .pwm_period_start(tbase == 10'h00f), .adc_enabled(adc_en),
    .adc_start(adc_go), .special_event_trigger(sev), .unit_pin_out(pin),
    .unit_pin_drive_n(pin_n), .unit_event_flag(evf), .unit_event_enable(eve));
  ccu_timer_model ccu_timer_model_inst (.pclk(pclk), .presetn(presetn),
    .run(run), .load(load), .load_val(load_val), .timer_clear(tclr),
    .timer_one(tmr));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tmo();
    fail_count++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; pready is sampled at the rising edge, as the slave
  // sees it, and the answer is taken at that same edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) tmo();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask
  task automatic ld(input logic [15:0] v);
    @(posedge pclk);
    load <= 1'b1;
    load_val <= v;
    @(posedge pclk);
    load <= 1'b0;
  endtask
  task automatic wait_pin(input logic e);
    int n;
    n = 0;
    while (pin !== e && n < 100) begin
      @(negedge pclk);
      n++;
    end
    if (pin !== e) tmo();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk(pin, 1'h0);
    chk(pin_n, 1'h1);
    rdc(ccu_pkg::OFS_CONTROL, 8'h00);
    rdc(ccu_pkg::OFS_FLAGS, 8'h00);
    wr(ccu_pkg::OFS_ENABLES, 8'h21);
    rdc(ccu_pkg::OFS_ENABLES, 8'h21);
    chk(eve, 1'h1);
    rdc(8'h14, 8'h00);
    chk(err, 1'h1);
  endtask
  // Each mode first sees a count that differs only in its high byte.
  task automatic t_modes();
    logic [3:0] m[4];
    logic e[4];
    m = '{ccu_pkg::MODE_TOGGLE, ccu_pkg::MODE_CLEAR, ccu_pkg::MODE_SET,
          ccu_pkg::MODE_SOFT_IRQ};
    e = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr(ccu_pkg::OFS_VALUE_LOW, 8'h34);
    wr(ccu_pkg::OFS_VALUE_HIGH, 8'h12);
    rdc(ccu_pkg::OFS_VALUE_HIGH, 8'h12);
    for (int i = 0; i < 4; i++) begin
      ld(16'h0234);
      wr(ccu_pkg::OFS_CONTROL, {4'h0, m[i]});
      wr(ccu_pkg::OFS_FLAGS, 8'h00);
      rdc(ccu_pkg::OFS_FLAGS, 8'h00);
      ld(16'h1234);
      repeat (3) @(posedge pclk);
      chk(evf, 1'h1);
      chk(pin, e[i]);
      chk(pin_n, i == 3);
      rdc(ccu_pkg::OFS_FLAGS, 8'h20);
      wr(ccu_pkg::OFS_FLAGS, 8'h00);
      rdc(ccu_pkg::OFS_FLAGS, 8'h00);
      chk(pin, e[i]);
    end
  endtask
  task automatic t_off();
    wr(ccu_pkg::OFS_CONTROL, 8'h00);
    // The write lands at the last edge; the latch clears one edge later.
    repeat (2) @(posedge pclk);
    chk(pin, 1'h0);
    chk(pin_n, 1'h1);
  endtask
  task automatic t_special();
    wr(ccu_pkg::OFS_VALUE_HIGH, 8'h00);
    wr(ccu_pkg::OFS_VALUE_LOW, 8'h10);
    ld(16'h0008);
    adc_en <= 1'b1;
    wr(ccu_pkg::OFS_CONTROL, {4'h0, ccu_pkg::MODE_SPECIAL});
    wr(ccu_pkg::OFS_FLAGS, 8'h00);
    adc_cnt = 0;
    sp_on = 1;
    run <= 1'b1;
    repeat (60) @(posedge pclk);
    chk(adc_cnt > 0, 1'h1);
    chk(sev_bad, 0);
    chk(pin_n, 1'h1);
    rdc(ccu_pkg::OFS_FLAGS, 8'h20);
    adc_en <= 1'b0;
    @(posedge pclk);
    adc_cnt = 0;
    repeat (40) @(posedge pclk);
    chk(adc_cnt, 0);
    run <= 1'b0;
    sp_on = 0;
  endtask
  // Duty of four time-base steps gives a high time of five cycles.
  task automatic t_pwm();
    int w;
    w = 0;
    wr(ccu_pkg::OFS_VALUE_LOW, 8'h01);
    wr(ccu_pkg::OFS_CONTROL, 8'h0c);
    wait_pin(1'b1);
    wait_pin(1'b0);
    wait_pin(1'b1);
    chk(pin_n, 1'h0);
    while (pin === 1'b1 && w < 40) begin
      @(negedge pclk);
      w++;
    end
    chk(w, 5);
    wr(ccu_pkg::OFS_CONTROL, 8'h00);
    repeat (2) @(posedge pclk);
    chk(pin_n, 1'h1);
    chk(pin, 1'h0);
  endtask
  // Reset for six cycles, then run every scenario in turn.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_off();
    t_special();
    t_pwm();
    give_verdict();
  end
endmodule // tb_ccu_compare_unit
`default_nettype wire
